// ===== medi_engine_data_if.sv
`timescale 1ns/1ps
module medi_engine_data_if #(
  parameter int unsigned TICK_DIV = medi_pkg::TICK_CYCLES  // Cycles per front-end tick
) (
  input  wire logic              clock_i,            // System clock
  input  wire logic              nrst_i,             // Synchronous reset, active low
  input  wire medi_pkg::medi_req_t reg_req_i,        // Register port request
  output logic [7:0]             reg_rdata_o,        // Read data, cycle after read
  input  wire medi_pkg::medi_smp_t afe_sample_i,     // Local converter result
  input  wire medi_pkg::medi_smp_t remote_sample_i,  // Remote sensor result
  output logic [3:0]             input_slot_handle_o,// Handle being converted
  output logic                   pass_done_o,        // Engine pass complete pulse
  output logic                   accum_done_o,       // Interval complete pulse
  output logic                   engine_enable_o,    // Engine running
  output logic [5:0]             engine_code_location_o, // Code location field
  output medi_pkg::medi_map_t    element_map_o,      // Equation element mapping
  output logic                   irq_o               // Level interrupt
);
  import medi_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  medi_state_t q;        // Registered state
  medi_state_t d;        // Next state
  logic        tick;     // One-cycle front-end tick enable
  logic        cpu_ram;  // Register access hits engine RAM
  logic [3:0]  cpu_word; // Engine word addressed by processor
  logic [4:0]  cpu_lane; // Bit offset of addressed byte
  logic [3:0]  cps;      // Ticks per slot
  logic        slot_end; // Conversion slot completes this tick
  logic        sample_wr;// Local sample stored this cycle
  logic [1:0]  events;   // Hardware events this cycle

  // Handle for slot k; absent inputs are skipped
  function automatic logic [3:0] slot_handle(input logic [3:0] k, input logic da,
                                             input logic db, input logic rm);
    logic [5:0][3:0] lst;
    logic [2:0]      n;
    lst = {6{H_NONE}};
    n   = 3'h0;
    lst[n] = H_IA0;
    n = n + 3'h1;
    if (!da) begin
      lst[n] = H_IA1;
      n = n + 3'h1;
    end
    lst[n] = H_VA;
    n = n + 3'h1;
    if (!rm) begin
      lst[n] = H_IB2;
      n = n + 3'h1;
      if (!db) begin
        lst[n] = H_IB3;
        n = n + 3'h1;
      end
    end
    lst[n] = H_VB;
    n = n + 3'h1;
    // Remote B currents take no handle; B voltage moves up into the next free slot
    return (k < {1'b0, n}) ? lst[k[2:0]] : H_NONE;
  endfunction

  // ****************************************************************
  // Address decode and timing helpers
  // ****************************************************************
  always_comb begin
    cpu_ram   = (reg_req_i.addr < RAM_BYTES);
    cpu_word  = reg_req_i.addr[5:2];
    // Big-endian: byte 0 is bits 31:24, byte 3 is bits 7:0
    cpu_lane  = {~reg_req_i.addr[1:0], 3'h0};
    tick      = (q.div_cnt == DIV_W'(TICK_DIV - 1));
    cps       = SLOT_CYCLES[q.filter_length_code];
    slot_end  = tick && q.eng_en && (q.frame_tick < CONV_TICKS) &&
                (q.slot_tick == cps - 4'h1);
    // Only slots within the configured count convert
    sample_wr = slot_end && (q.slot_idx < q.conv_per_frame) && (q.handle != H_NONE);
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    d             = q;
    d.pass_pulse  = 1'b0;
    d.accum_pulse = 1'b0;
    d.rdata       = 8'h00;
    events        = 2'h0;

    // Front-end tick divider, free running
    d.div_cnt = tick ? '0 : q.div_cnt + DIV_W'(1);

    // Frame sequencing: 12 conversion ticks then one settle tick
    if (!q.eng_en) begin
      d.frame_tick = 4'h0;
      d.slot_tick  = 4'h0;
      d.slot_idx   = 4'h0;
      d.samp_cnt   = 13'h0000;
      d.handle     = slot_handle(4'h0, q.diffa, q.diffb, q.rmt);
    end else if (tick) begin
      if (q.frame_tick == FRAME_TICKS - 4'h1) begin
        // Settle tick closes the frame: one sample counted per frame
        d.frame_tick = 4'h0;
        d.slot_tick  = 4'h0;
        d.slot_idx   = 4'h0;
        d.handle     = slot_handle(4'h0, q.diffa, q.diffb, q.rmt);
        d.pass_pulse = 1'b1;
        events[IRQ_PASS] = 1'b1;
        // Interval spans exactly acc_count sample periods
        if ((q.acc_count != 13'h0000) && (q.samp_cnt + 13'h0001 >= q.acc_count)) begin
          d.samp_cnt        = 13'h0000;
          d.accum_pulse     = 1'b1;
          events[IRQ_ACCUM] = 1'b1;
        end else begin
          d.samp_cnt = q.samp_cnt + 13'h0001;
        end
      end else begin
        d.frame_tick = q.frame_tick + 4'h1;
        if (q.frame_tick < CONV_TICKS) begin
          if (slot_end) begin
            d.slot_tick = 4'h0;
            d.slot_idx  = q.slot_idx + 4'h1;
            d.handle    = slot_handle(q.slot_idx + 4'h1, q.diffa, q.diffb, q.rmt);
          end else begin
            d.slot_tick = q.slot_tick + 4'h1;
          end
        end
      end
    end

    // Processor register writes
    if (reg_req_i.wr) begin
      if (cpu_ram) begin
        d.ram[cpu_word][cpu_lane +: 8] = reg_req_i.wdata;
      end else begin
        unique case (reg_req_i.addr)
          ADDR_MUX_FRAME: d.conv_per_frame = reg_req_i.wdata[POS_CONV +: 4];
          ADDR_EQU_EN: begin
            d.meter_equation_select    = reg_req_i.wdata[POS_EQU +: 3];
            // Software must have loaded calibration before this
            d.eng_en = reg_req_i.wdata[POS_EN];
          end
          ADDR_CNT_HI:   d.acc_count[12:8] = reg_req_i.wdata[4:0];
          ADDR_CNT_LO:   d.acc_count[7:0]  = reg_req_i.wdata;
          ADDR_CODE_LOC: d.code_loc = reg_req_i.wdata[5:0];
          ADDR_DIFF_FIR: begin
            d.diffa   = reg_req_i.wdata[POS_DIFFA];
            d.diffb   = reg_req_i.wdata[POS_DIFFB];
            d.filter_length_code = reg_req_i.wdata[POS_FIR +: 2];
          end
          ADDR_REMOTE:   d.rmt = reg_req_i.wdata[POS_RMT];
          ADDR_IRQ_STAT: d.irq_stat = q.irq_stat & ~reg_req_i.wdata[1:0];
          ADDR_IRQ_MASK: d.irq_mask = reg_req_i.wdata[1:0];
          default: begin
            // Unmapped write is ignored
          end
        endcase
      end
    end

    // Hardware sample writes win over a processor byte write
    if (sample_wr) begin
      d.ram[q.handle] = afe_sample_i.data;
    end
    // Remote B result lands in word 2 only while the engine runs, word 3 left alone
    if (q.eng_en && q.rmt && remote_sample_i.valid) begin
      d.ram[H_IB2] = remote_sample_i.data;
    end

    // Sticky events: a set wins over a same-cycle clear
    d.irq_stat = d.irq_stat | events;

    // Register reads, answered the following cycle
    if (reg_req_i.rd) begin
      if (cpu_ram) begin
        d.rdata = q.ram[cpu_word][cpu_lane +: 8];
      end else begin
        unique case (reg_req_i.addr)
          ADDR_MUX_FRAME: d.rdata = {q.conv_per_frame, 4'h0};
          ADDR_EQU_EN:    d.rdata = {q.meter_equation_select, 4'h0, q.eng_en};
          ADDR_CNT_HI:    d.rdata = {3'h0, q.acc_count[12:8]};
          ADDR_CNT_LO:    d.rdata = q.acc_count[7:0];
          ADDR_CODE_LOC:  d.rdata = {2'h0, q.code_loc};
          ADDR_DIFF_FIR:  d.rdata = {2'h0, q.diffb, q.diffa, 1'b0, q.filter_length_code, 1'b0};
          ADDR_REMOTE:    d.rdata = {4'h0, q.rmt, 3'h0};
          ADDR_IRQ_STAT:  d.rdata = {6'h00, q.irq_stat};
          ADDR_IRQ_MASK:  d.rdata = {6'h00, q.irq_mask};
          default:        d.rdata = 8'h00;
        endcase
      end
    end

    // Equation element mapping
    unique case (q.meter_equation_select)
      3'h0: d.map = '{PROD_VA_IA, PROD_VA_IB, CUR_IA, CUR_NONE};
      3'h1: d.map = '{PROD_VA_IAMIB_HALF, PROD_NONE, CUR_IAMIB, CUR_IB};
      3'h2: d.map = '{PROD_VA_IA, PROD_VB_IB, CUR_IA, CUR_IB};
      default: d.map = '{PROD_NONE, PROD_NONE, CUR_NONE, CUR_NONE};
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      q                <= '0;
      q.conv_per_frame <= CONV_RST;
      q.filter_length_code        <= FIR_RST;
      q.handle         <= H_IA0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o            = q.rdata;
  assign input_slot_handle_o    = q.handle;
  assign pass_done_o            = q.pass_pulse;
  assign accum_done_o           = q.accum_pulse;
  assign engine_enable_o        = q.eng_en;
  assign engine_code_location_o = q.code_loc;
  assign element_map_o          = q.map;
  assign irq_o                  = |(q.irq_stat & q.irq_mask);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  logic [4:0]  ticks_since; // Ticks since last pass pulse
  logic        seen_pass;   // A pass pulse has occurred
  logic [12:0] frames_since;// Frames since last interval end
  always_ff @(posedge clock_i) begin
    if (!nrst_i || !q.eng_en) begin
      ticks_since  <= 5'h00;
      seen_pass    <= 1'b0;
      frames_since <= 13'h0000;
    end else begin
      if (q.pass_pulse) begin
        ticks_since <= {4'h0, tick};
        seen_pass   <= 1'b1;
      end else if (tick) begin
        ticks_since <= ticks_since + 5'h01;
      end
      if (q.accum_pulse) begin
        frames_since <= 13'h0000;
      end else if (q.pass_pulse) begin
        frames_since <= frames_since + 13'h0001;
      end
    end
  end

  sequence s_read_ram;
    reg_req_i.rd && cpu_ram && reg_req_i.addr[1:0] == 2'h0;
  endsequence

  a_msb_first_read: assert property (s_read_ram ##1 1'b1 |->
    reg_rdata_o == $past(q.ram[cpu_word][31:24]))
    else $error("Byte 0 of a word must be its top byte");
  a_sample_full_word: assert property (sample_wr |=>
    q.ram[$past(q.handle)] == $past(afe_sample_i.data))
    else $error("Sample not stored as a whole word");
  a_frame_thirteen: assert property (q.pass_pulse && seen_pass |->
    ticks_since == 5'h0D)
    else $error("Frame is not thirteen ticks");
  a_interval_len: assert property (q.accum_pulse && frames_since != 13'h0000 |->
    frames_since + 13'h0001 == q.acc_count)
    else $error("Interval length differs from count");
  a_reset_default: assert property ($rose(nrst_i) |->
    q.filter_length_code == FIR_RST && q.conv_per_frame == CONV_RST)
    else $error("Wrong reset configuration");
  a_equ_one_map: assert property (q.meter_equation_select == 3'h1 |=>
    element_map_o.elem0 == PROD_VA_IAMIB_HALF && element_map_o.isq1 == CUR_IB)
    else $error("Equation 1 mapping wrong");
  a_diff_a_keep: assert property (
    q.diffa && !(reg_req_i.wr && cpu_ram && cpu_word == 4'h1) |=> $stable(q.ram[1]))
    else $error("Word 1 disturbed in A differential mode");
  a_remote_keep: assert property (
    q.rmt && !(reg_req_i.wr && cpu_ram && cpu_word == 4'h3) |=> $stable(q.ram[3]))
    else $error("Word 3 disturbed with remote sensor");
  a_b_diff_handle: assert property (!q.rmt && q.diffb |-> q.handle != H_IB3)
    else $error("Handle 3 used in B differential mode");
  a_voltage_slot: assert property (sample_wr && q.handle > H_IB3 |->
    q.handle == H_VA || q.handle == H_VB)
    else $error("Voltage sample at wrong location");
  a_pass_irq: assert property (q.pass_pulse |-> q.irq_stat[IRQ_PASS]
    ##1 (q.irq_stat[IRQ_PASS] || $past(reg_req_i.wr)))
    else $error("Pass event not recorded");

endmodule

// ===== medi_fe_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Front end and remote sensor stand-in
// ****************************************************************
module medi_fe_model (
  input  wire logic          clock_i,             // System clock
  input  wire logic [3:0]    input_slot_handle_i, // Handle being converted
  input  wire logic          send_remote_i,       // Ask for one remote sample
  output medi_pkg::medi_smp_t afe_sample_o,       // Converter result
  output medi_pkg::medi_smp_t remote_sample_o     // Remote result
);
  import medi_pkg::*;

  // Converter result follows the selected input for the whole slot
  always_comb begin
    afe_sample_o.data  = {input_slot_handle_i, 4'h1, input_slot_handle_i, 4'h2,
                          input_slot_handle_i, 4'h3, input_slot_handle_i, 4'h4};
    afe_sample_o.valid = 1'b1;
  end

  // Remote word for one cycle; data scrambled while idle
  initial remote_sample_o = '0;
  always @(posedge clock_i) begin
    remote_sample_o.valid <= send_remote_i;
    remote_sample_o.data  <= send_remote_i ? 32'h8765_4321 : ~remote_sample_o.data;
  end
endmodule

// ===== medi_pkg.sv
// ****************************************************************
// Metering engine data interface: shared constants and types
// ****************************************************************
package medi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 250_000_000;     // System clock rate
  localparam int unsigned FE_CLK_HZ    = 32768;           // Front-end clock rate
  localparam int unsigned TICK_CYCLES  = CLK_HZ / FE_CLK_HZ; // Cycles per front-end tick
  localparam int          DIV_W        = 16;              // Tick divider width
  localparam logic [3:0]  FRAME_TICKS  = 4'hD;            // Ticks per mux frame
  localparam logic [3:0]  CONV_TICKS   = 4'hC;            // Ticks usable by slots
  // Ticks per slot for each filter length code 3..0
  localparam logic [3:0][3:0] SLOT_CYCLES = {4'h6, 4'h4, 4'h3, 4'h2};

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [15:0] ADDR_MUX_FRAME  = 16'h2100;  // mux_frame_control
  localparam logic [15:0] ADDR_EQU_EN     = 16'h2106;  // equation_and_engine_enable
  localparam logic [15:0] ADDR_CNT_HI     = 16'h2107;  // accumulation_count_high
  localparam logic [15:0] ADDR_CNT_LO     = 16'h2108;  // accumulation_count_low
  localparam logic [15:0] ADDR_CODE_LOC   = 16'h2109;  // engine_code_location
  localparam logic [15:0] ADDR_DIFF_FIR   = 16'h210C;  // input_differential_filter_control
  localparam logic [15:0] ADDR_REMOTE     = 16'h2709;  // remote_sensor_control
  localparam logic [15:0] ADDR_IRQ_STAT   = 16'h2110;  // Sticky event status
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'h2111;  // Event mask
  localparam logic [15:0] RAM_BYTES       = 16'h0040;  // Engine RAM byte span
  localparam int          RAM_WORDS       = 16;        // Engine RAM words

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          POS_CONV   = 4;    // conversions_per_frame [7:4]
  localparam int          POS_EQU    = 5;    // meter_equation_select [7:5]
  localparam int          POS_EN     = 0;    // Engine enable bit
  localparam int          POS_FIR    = 1;    // filter_length_code [2:1]
  localparam int          POS_DIFFA  = 4;    // current_a_differential_enable
  localparam int          POS_DIFFB  = 5;    // current_b_differential_enable
  localparam int          POS_RMT    = 3;    // remote_sensor_enable
  localparam int          IRQ_PASS   = 0;    // Pass-complete event bit
  localparam int          IRQ_ACCUM  = 1;    // Accumulation-done event bit
  localparam logic [3:0]  CONV_RST   = 4'h3; // Default conversions per frame
  localparam logic [1:0]  FIR_RST    = 2'h1; // Default filter length code

  // ****************************************************************
  // Input slot handles
  // ****************************************************************
  localparam logic [3:0] H_IA0  = 4'h0;  // A current, positive or differential
  localparam logic [3:0] H_IA1  = 4'h1;  // A current, negative pin
  localparam logic [3:0] H_IB2  = 4'h2;  // B current, positive or differential
  localparam logic [3:0] H_IB3  = 4'h3;  // B current, negative pin
  localparam logic [3:0] H_VB   = 4'h9;  // B voltage
  localparam logic [3:0] H_VA   = 4'hA;  // A voltage
  localparam logic [3:0] H_NONE = 4'hF;  // No conversion in this slot

  // ****************************************************************
  // Equation element mapping
  // ****************************************************************
  typedef enum logic [2:0] {PROD_NONE, PROD_VA_IA, PROD_VA_IB, PROD_VA_IAMIB_HALF,
                            PROD_VB_IB} medi_prod_t;
  typedef enum logic [1:0] {CUR_NONE, CUR_IA, CUR_IB, CUR_IAMIB} medi_cur_t;

  typedef struct packed {
    medi_prod_t elem0;   // Product feeding the first energy sum
    medi_prod_t elem1;   // Product feeding the second energy sum
    medi_cur_t  isq0;    // Current for the first squared sum
    medi_cur_t  isq1;    // Current for the second squared sum
  } medi_map_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;   // Byte address
    logic [7:0]  wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } medi_req_t;

  // Front-end sample strobe
  typedef struct packed {
    logic [31:0] data;   // Two's complement sample
    logic        valid;  // Sample present
  } medi_smp_t;

  // Whole block state
  typedef struct packed {
    logic [RAM_WORDS-1:0][31:0] ram;  // Engine data words
    logic [7:0]  rdata;               // Read data
    logic [DIV_W-1:0] div_cnt;        // Tick divider
    logic [3:0]  frame_tick;          // Tick within frame
    logic [3:0]  slot_tick;           // Tick within slot
    logic [3:0]  slot_idx;            // Conversion slot within frame
    logic [3:0]  handle;              // Handle of slot in progress
    logic [12:0] samp_cnt;            // Samples in this interval
    logic        pass_pulse;          // Frame complete
    logic        accum_pulse;         // Interval complete
    medi_map_t   map;                 // Decoded equation mapping
    logic [3:0]  conv_per_frame;
    logic [2:0]  meter_equation_select;
    logic        eng_en;
    logic [12:0] acc_count;
    logic [5:0]  code_loc;
    logic        diffa;
    logic        diffb;
    logic [1:0]  filter_length_code;
    logic        rmt;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
  } medi_state_t;

endpackage

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import medi_pkg::*;
  localparam int unsigned TDIV = 4; // Short front-end tick
  logic      clock_i = 1'b0;
  logic      nrst_i  = 1'b0;
  medi_req_t req     = '0;
  logic      send_rmt = 1'b0;
  medi_smp_t afe, rmt;
  logic [7:0] rdata;
  logic [3:0] handle;
  logic       pass, accum, en, irq;
  logic [5:0] loc;
  medi_map_t  emap;
  int n_mismatch = 0;
  int total_checks = 0;
  always #2 clock_i = ~clock_i;

  medi_engine_data_if #(.TICK_DIV(TDIV)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .afe_sample_i(afe), .remote_sample_i(rmt),
    .input_slot_handle_o(handle), .pass_done_o(pass), .accum_done_o(accum),
    .engine_enable_o(en), .engine_code_location_o(loc), .element_map_o(emap), .irq_o(irq));
  medi_fe_model fe_u (.clock_i(clock_i), .input_slot_handle_i(handle),
    .send_remote_i(send_rmt), .afe_sample_o(afe), .remote_sample_o(rmt));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  function automatic logic [31:0] fe(input logic [3:0] h);
    return {h, 4'h1, h, 4'h2, h, 4'h3, h, 4'h4};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Word access, most significant byte at the lowest address
  task automatic rd_word(input int w, output logic [31:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      rd(16'(4 * w + i), b);
      v = {v[23:0], b};
    end
  endtask
  task automatic wr_word(input int w, input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(16'(4 * w + i), v[31 - 8 * i -: 8]);
  endtask
  task automatic chk_word(input int w, input logic [31:0] exp);
    logic [31:0] v;
    rd_word(w, v);
    chk(v, exp, "word");
  endtask
  // Waits for a frame-end pulse; k is the cycle count
  task automatic wait_pass(output int k);
    k = 0;
    do begin
      @(posedge clock_i);
      #1 k++;
    end while (pass !== 1'b1 && k < 300);
    if (pass !== 1'b1) begin
      chk(0, 1, "pass timeout");
      wrap_up();
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] b;
    rd(ADDR_MUX_FRAME, b);
    chk(b[7:4], 4'h3, "conv default");
    rd(ADDR_DIFF_FIR, b);
    chk(b[2:1], 2'h1, "fir default");
    rd(16'h3000, b);
    chk(b, 8'h00, "unmapped");
  endtask
  task automatic t_equ();
    medi_map_t m [3];
    m[0] = '{PROD_VA_IA, PROD_VA_IB, CUR_IA, CUR_NONE};
    m[1] = '{PROD_VA_IAMIB_HALF, PROD_NONE, CUR_IAMIB, CUR_IB};
    m[2] = '{PROD_VA_IA, PROD_VB_IB, CUR_IA, CUR_IB};
    for (int e = 0; e < 3; e++) begin
      wr(ADDR_EQU_EN, {3'(e), 5'h00});
      @(posedge clock_i);
      #1 chk(32'(emap), 32'(m[e]), "equation map");
    end
  endtask
  task automatic t_default();
    int k;
    wr_word(9, 32'hFFFF_FFFF);
    wr(ADDR_CODE_LOC, 8'h2A);
    wr(ADDR_EQU_EN, 8'h01);
    @(posedge clock_i);
    #1 chk(loc, 6'h2A, "code location");
    chk(en, 1'b1, "engine enable");
    wait_pass(k);
    wait_pass(k);
    chk(k, 13 * TDIV, "frame length");
    for (int w = 0; w < 11; w = w + (w == 1 ? 9 : 1)) chk_word(w, fe(w[3:0]));
    chk_word(9, 32'hFFFF_FFFF);
  endtask
  task automatic t_diff();
    int k;
    wr(ADDR_EQU_EN, 8'h00);
    wr_word(1, 32'h1357_9BDF);
    wr_word(3, 32'h2468_ACE0);
    wr(ADDR_DIFF_FIR, 8'h32);
    wr(ADDR_EQU_EN, 8'h01);
    wait_pass(k);
    wait_pass(k);
    chk_word(1, 32'h1357_9BDF);
    chk_word(2, fe(4'h2));
    chk_word(3, 32'h2468_ACE0);
  endtask
  task automatic t_remote();
    int k;
    wr(ADDR_EQU_EN, 8'h00);
    wr_word(2, 32'h0BAD_F00D);
    wr(ADDR_DIFF_FIR, 8'h02);
    wr(ADDR_MUX_FRAME, 8'h40);
    wr(ADDR_REMOTE, 8'h08);
    wr(ADDR_EQU_EN, 8'h01);
    wait_pass(k);
    wait_pass(k);
    chk_word(9, fe(4'h9));
    chk_word(10, fe(4'hA));
    chk_word(2, 32'h0BAD_F00D);
    @(posedge clock_i);
    send_rmt <= 1'b1;
    @(posedge clock_i);
    send_rmt <= 1'b0;
    chk_word(2, 32'h8765_4321);
    chk_word(3, 32'h2468_ACE0);
  endtask
  task automatic t_irq();
    logic [7:0] b;
    wr(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_IRQ_STAT, b);
    chk(b[0], 1'b1, "pass status");
    chk(irq, 1'b0, "masked irq");
    wr(ADDR_IRQ_MASK, 8'h01);
    @(posedge clock_i);
    #1 chk(irq, 1'b1, "irq raised");
    wr(ADDR_EQU_EN, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h03);
    @(posedge clock_i);
    #1 chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_accum();
    int np;
    int k;
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_EQU_EN, 8'h01);
    np = 0;
    k = 0;
    do begin
      @(posedge clock_i);
      #1 k++;
      np += int'(pass === 1'b1);
    end while (accum !== 1'b1 && k < 400);
    if (accum !== 1'b1) begin
      chk(0, 1, "accum timeout");
      wrap_up();
    end
    chk(np, 2, "frames per interval");
    @(posedge clock_i);
    #1 chk(irq, 1'b1, "interval irq");
  endtask

  // ****************************************************************
  // Closing report
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_equ();
    t_default();
    t_diff();
    t_remote();
    t_irq();
    t_accum();
    wrap_up();
  end
endmodule
